//--- common/cgu_pkg.sv
// Constants shared by the clock generation unit
package cgu_pkg;
	// AXI4-Lite register byte offsets
	localparam logic [7:0] ctrl_offset     = 8'h00;
	localparam logic [7:0] divider_offset  = 8'h04;
	localparam logic [7:0] gate_offset     = 8'h08;
	localparam logic [7:0] power_offset    = 8'h0C;
	localparam logic [7:0] status_offset   = 8'h10;
	// Control register fields
	localparam int ctrl_osc_disconnect_bit = 0;
	localparam int ctrl_vco_bypass_bit     = 1;
	localparam int ctrl_ext_osc_bit        = 2;
	localparam int ctrl_toggle_latch_bit   = 3;
	localparam int ctrl_clock_output_pin_sel_lsb     = 4;
	// Divider register fields
	localparam int div_feedback_divider_select_lsb            = 0;
	localparam int div_slowdown_lsb        = 8;
	// Status fields
	localparam int stat_osc_fail_bit       = 0;
	localparam int stat_lock_fail_bit      = 1;
	localparam int stat_mode_lsb           = 2;
	localparam int stat_power_lsb          = 4;
	// Reset values
	localparam logic [7:0] feedback_divider_select_reset      = 8'h10;
	localparam logic [3:0] slowdown_reset  = 4'h1;
	localparam logic [2:0] gate_reset      = 3'h7;
	// Fixed divide factors
	localparam int p_factor                = 1;
	localparam int k_factor                = 2;
	localparam int core_ratio              = 3;
	// Loss detection window in cycles of the clock input
	localparam int osc_watch_cycles        = 64;
	localparam logic [1:0] axi_okay        = 2'b00;
	localparam logic [1:0] axi_slverr      = 2'b10;
	typedef enum logic [1:0] {mode_pll, mode_prescaler, mode_pll_base} clk_mode_t;
	typedef enum logic [1:0] {pwr_active, pwr_idle, pwr_slowdown, pwr_powerdown} power_t;
endpackage

//--- rtl/clock_divider.sv
// Programmable clock enable divider, reloads only at period end
`timescale 1ns/1ps
`default_nettype none
module clock_divider
#(
	parameter int width = 8
)
(
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             tick_in,
	input  wire logic [width-1:0] divide,
	output logic                  tick_out
);
	initial
	begin
		if (width < 2)
			$error("clock_divider width too small");
	end
	logic [width-1:0] count_q;
	logic [width-1:0] limit_q;
	logic             out_q;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			count_q <= '0;
			limit_q <= '0;
			out_q   <= 1'b0;
		end
		else
		begin
			out_q <= 1'b0;
			if (tick_in)
			begin
				// New factor only taken at a period boundary: no short pulse
				if (count_q >= limit_q)
				begin
					count_q <= '0;
					limit_q <= (divide == '0) ? '0 : divide - 1'b1;
					out_q   <= 1'b1;
				end
				else
					count_q <= count_q + 1'b1;
			end
		end
	end
	assign tick_out = out_q;
endmodule
`default_nettype wire

//--- rtl/clock_gen_unit.sv
// Clock generation unit: mode select, dividers, gating, loss detection
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_unit
	import cgu_pkg::*;
#(
	parameter int feedback_divider_select_width = 8,
	parameter int slow_width = 4
)
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        watchdog_rst,
	input  wire logic        osc_tick_int,
	input  wire logic        osc_tick_ext,
	input  wire logic        vco_tick,
	input  wire logic        vco_base_tick,
	input  wire logic        pll_locked,
	input  wire logic        wake_irq,
	output logic             sys_tick,
	output logic             cpu_clock,
	output logic             periph_clock,
	output logic             fast_capture_clock,
	output logic             flash_fast_clock,
	output logic             clock_output_pin,
	output logic             osc_enable,
	output logic             pll_enable,
	output logic             ext_osc_select,
	output logic [feedback_divider_select_width-1:0] feedback_divider_select,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	initial
	begin
		if (feedback_divider_select_width > 8 || feedback_divider_select_width < 5 || slow_width > 8 || slow_width < 2)
			$error("clock_gen_unit width out of range");
	end

	// Control state
	logic                  osc_disconnect_q;
	logic                  vco_bypass_q;
	logic                  ext_osc_q;
	logic                  toggle_latch_enable_q;
	logic [1:0]            clock_output_pin_sel_q;
	logic [feedback_divider_select_width-1:0] feedback_divider_select_q;
	logic [slow_width-1:0] slowdown_divider_q;
	logic [2:0]            gate_q;
	power_t                power_q;
	logic                  osc_fail_q;
	logic                  lock_fail_q;
	clk_mode_t             mode_q;
	logic                  any_rst;
	assign any_rst = rst | watchdog_rst;

	// Synchronised asynchronous inputs
	logic [1:0] osc_int_s, osc_ext_s, vco_s, base_s, lock_s;
	always_ff @(posedge clock)
	begin
		osc_int_s <= {osc_int_s[0], osc_tick_int};
		osc_ext_s <= {osc_ext_s[0], osc_tick_ext};
		vco_s     <= {vco_s[0], vco_tick};
		base_s    <= {base_s[0], vco_base_tick};
		lock_s    <= {lock_s[0], pll_locked};
	end
	logic osc_lvl, osc_prev_q, vco_prev_q, base_prev_q;
	logic osc_edge, vco_edge, base_edge;
	assign osc_lvl = ext_osc_q ? osc_ext_s[1] : osc_int_s[1];
	always_ff @(posedge clock)
	begin
		osc_prev_q  <= osc_lvl;
		vco_prev_q  <= vco_s[1];
		base_prev_q <= base_s[1];
	end
	assign osc_edge  = osc_lvl & ~osc_prev_q;
	assign vco_edge  = vco_s[1] & ~vco_prev_q;
	assign base_edge = base_s[1] & ~base_prev_q;

	// AXI4-Lite slave
	logic       aw_held_q, w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic       do_write;
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
	assign do_write      = aw_held_q & w_held_q & ~s_axi_bvalid;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= '0;
			wdata_q      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= axi_okay;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end
			if (do_write)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == ctrl_offset || awaddr_q == divider_offset ||
					awaddr_q == gate_offset || awaddr_q == power_offset ||
					awaddr_q == status_offset) ? axi_okay : axi_slverr;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Oscillator and PLL settings: only power-on reset clears them
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			osc_disconnect_q      <= 1'b0;
			vco_bypass_q          <= 1'b0;
			ext_osc_q             <= 1'b0;
			toggle_latch_enable_q <= 1'b0;
			clock_output_pin_sel_q          <= '0;
			feedback_divider_select_q                <= feedback_divider_select_reset[feedback_divider_select_width-1:0];
			slowdown_divider_q    <= slowdown_reset[slow_width-1:0];
		end
		else if (do_write && awaddr_q == ctrl_offset)
		begin
			osc_disconnect_q      <= wdata_q[ctrl_osc_disconnect_bit];
			vco_bypass_q          <= wdata_q[ctrl_vco_bypass_bit];
			ext_osc_q             <= wdata_q[ctrl_ext_osc_bit];
			toggle_latch_enable_q <= wdata_q[ctrl_toggle_latch_bit];
			clock_output_pin_sel_q          <= wdata_q[ctrl_clock_output_pin_sel_lsb +: 2];
		end
		else if (do_write && awaddr_q == divider_offset)
		begin
			feedback_divider_select_q             <= wdata_q[div_feedback_divider_select_lsb +: feedback_divider_select_width];
			slowdown_divider_q <= wdata_q[div_slowdown_lsb +: slow_width];
		end
	end

	// Module gates and power mode, reset to all gates on and active by every reset
	always_ff @(posedge clock)
	begin
		if (any_rst)
		begin
			gate_q  <= gate_reset;
			power_q <= pwr_active;
		end
		else
		begin
			if (do_write && awaddr_q == gate_offset)
				gate_q <= wdata_q[2:0];
			if (power_q == pwr_idle && wake_irq)
				power_q <= pwr_active;
			else if (do_write && awaddr_q == power_offset)
			begin
				// Saving modes only entered from active; a write of active is taken from any mode
				if (power_q == pwr_active || wdata_q[1:0] == 2'b00)
					power_q <= power_t'(wdata_q[1:0]);
			end
		end
	end

	// Mode decode; taken only at a system tick so the switch lands on a period edge
	clk_mode_t mode_d;
	always_comb
	begin
		if (osc_disconnect_q)
			mode_d = mode_pll_base;
		else if (vco_bypass_q)
			mode_d = mode_prescaler;
		else
			mode_d = mode_pll;
	end

	// System tick source. VCO runs at osc*N/P; base VCO free-running.
	logic src_tick;
	always_comb
	begin
		unique case (mode_q)
			mode_pll:       src_tick = vco_edge;
			mode_prescaler: src_tick = osc_edge;
			mode_pll_base:  src_tick = base_edge;
			default:        src_tick = osc_edge;
		endcase
	end

	logic [1:0] k_count_q;
	logic       sys_q;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			k_count_q <= '0;
			sys_q     <= 1'b0;
			mode_q    <= mode_pll;
		end
		else
		begin
			sys_q <= 1'b0;
			if (power_q == pwr_powerdown)
				k_count_q <= '0;
			else if (src_tick)
			begin
				// Fixed K divide, P is one so no input prescale stage
				if (k_count_q == 2'(k_factor * p_factor - 1))
				begin
					k_count_q <= '0;
					sys_q     <= 1'b1;
					mode_q    <= mode_d;
				end
				else
					k_count_q <= k_count_q + 1'b1;
			end
		end
	end
	assign sys_tick         = sys_q;
	assign flash_fast_clock = sys_q;

	// Core clock at one third of system
	logic [1:0] core_count_q;
	logic       core_q;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			core_count_q <= '0;
			core_q       <= 1'b0;
		end
		else
		begin
			core_q <= 1'b0;
			if (sys_q)
			begin
				if (core_count_q == 2'(core_ratio - 1))
				begin
					core_count_q <= '0;
					core_q       <= 1'b1;
				end
				else
					core_count_q <= core_count_q + 1'b1;
			end
		end
	end

	// Shared slow-down divider for CPU and peripherals
	logic slow_tick;
	logic [slow_width-1:0] slow_factor;
	assign slow_factor = (power_q == pwr_slowdown) ? slowdown_divider_q : slow_width'(1);
	clock_divider #(.width(slow_width)) slow_div
	(
		.clock    (clock),
		.rst      (rst),
		.tick_in  (core_q),
		.divide   (slow_factor),
		.tick_out (slow_tick)
	);

	// Output gating per module
	logic running;
	assign running            = power_q != pwr_powerdown;
	assign cpu_clock          = slow_tick & running & (power_q != pwr_idle);
	assign periph_clock       = slow_tick & running & gate_q[0];
	assign fast_capture_clock = slow_tick & running & gate_q[1];
	assign osc_enable         = running;
	// VCO stays on until a switch to prescaler has landed; the tick that moves the mode may need it
	assign pll_enable         = running & ~(mode_q == mode_prescaler && mode_d == mode_prescaler);
	assign ext_osc_select     = ext_osc_q;
	assign feedback_divider_select = feedback_divider_select_q;

	// Clock output pin with optional toggle stage
	logic out_src, clock_output_pin_q, toggle_q;
	always_comb
	begin
		unique case (clock_output_pin_sel_q)
			2'd0:    out_src = sys_q;
			2'd1:    out_src = core_q;
			2'd2:    out_src = osc_edge;
			default: out_src = slow_tick;
		endcase
	end
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			toggle_q <= 1'b0;
			clock_output_pin_q <= 1'b0;
		end
		else
		begin
			if (out_src)
				toggle_q <= ~toggle_q;
			clock_output_pin_q <= toggle_latch_enable_q ? toggle_q : out_src;
		end
	end
	assign clock_output_pin = clock_output_pin_q & gate_q[2];

	// Oscillator run and lock watch
	logic [6:0] osc_watch_q;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			osc_watch_q <= '0;
			osc_fail_q  <= 1'b0;
			lock_fail_q <= 1'b0;
		end
		else
		begin
			if (osc_edge || !running)
				osc_watch_q <= '0;
			else if (osc_watch_q != 7'(osc_watch_cycles))
				osc_watch_q <= osc_watch_q + 1'b1;
			// Set wins over software clear
			if (running && osc_watch_q == 7'(osc_watch_cycles - 1))
				osc_fail_q <= 1'b1;
			else if (do_write && awaddr_q == status_offset && wdata_q[stat_osc_fail_bit])
				osc_fail_q <= 1'b0;
			if (running && mode_q == mode_pll && !lock_s[1])
				lock_fail_q <= 1'b1;
			else if (do_write && awaddr_q == status_offset && wdata_q[stat_lock_fail_bit])
				lock_fail_q <= 1'b0;
		end
	end

	// Read channel
	logic [31:0] rdata_d;
	always_comb
	begin
		rdata_d = '0;
		unique case (s_axi_araddr)
			ctrl_offset:    rdata_d[5:0] = {clock_output_pin_sel_q, toggle_latch_enable_q, ext_osc_q,
				vco_bypass_q, osc_disconnect_q};
			divider_offset:
			begin
				rdata_d[div_feedback_divider_select_lsb +: feedback_divider_select_width]     = feedback_divider_select_q;
				rdata_d[div_slowdown_lsb +: slow_width] = slowdown_divider_q;
			end
			gate_offset:    rdata_d[2:0] = gate_q;
			power_offset:   rdata_d[1:0] = power_q;
			status_offset:
			begin
				rdata_d[stat_osc_fail_bit]    = osc_fail_q;
				rdata_d[stat_lock_fail_bit]   = lock_fail_q;
				rdata_d[stat_mode_lsb +: 2]   = mode_q;
				rdata_d[stat_power_lsb +: 2]  = power_q;
			end
			default:        rdata_d = '0;
		endcase
	end
	logic rd_ok;
	assign rd_ok = s_axi_araddr == ctrl_offset || s_axi_araddr == divider_offset ||
		s_axi_araddr == gate_offset || s_axi_araddr == power_offset || s_axi_araddr == status_offset;
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= axi_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdata_d;
			s_axi_rresp  <= rd_ok ? axi_okay : axi_slverr;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

//--- verif/clock_gen_unit_sva.sv
// Port checker for the clock generation unit
`timescale 1ns/1ps
`default_nettype none
module clock_gen_unit_sva
	import cgu_pkg::*;
#(
	parameter int feedback_divider_select_width = 8,
	parameter int slow_width = 4
)
(
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  watchdog_rst,
	input wire logic                  sys_tick,
	input wire logic                  cpu_clock,
	input wire logic                  periph_clock,
	input wire logic                  fast_capture_clock,
	input wire logic                  flash_fast_clock,
	input wire logic                  clock_output_pin,
	input wire logic                  osc_enable,
	input wire logic                  pll_enable,
	input wire logic                  ext_osc_select,
	input wire logic [feedback_divider_select_width-1:0] feedback_divider_select,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	flash_eq_a: assert property (flash_fast_clock == sys_tick)
		else $error("flash clock differs from system tick");
	tick_subset_a: assert property ((cpu_clock || periph_clock || fast_capture_clock) |-> $past(sys_tick, 2))
		else $error("derived clock pulse without system tick");
	cpu_gap_a: assert property (cpu_clock |=> (!cpu_clock) [*2])
		else $error("shortened cpu clock period");
	pd_off_a: assert property (!osc_enable |-> !pll_enable)
		else $error("pll left on with oscillator off");
	wdog_keep_a: assert property (watchdog_rst |=> $stable(ext_osc_select) && $stable(feedback_divider_select))
		else $error("watchdog reset changed clock settings");
	reset_vals_a: assert property ($fell(rst) |-> !sys_tick && !ext_osc_select && osc_enable &&
		feedback_divider_select == feedback_divider_select_reset && !s_axi_bvalid && !s_axi_rvalid)
		else $error("wrong state after reset");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	cover property (cpu_clock);
	cover property ($rose(clock_output_pin));
	cover property (!osc_enable);
endmodule
bind clock_gen_unit clock_gen_unit_sva #(.feedback_divider_select_width(feedback_divider_select_width), .slow_width(slow_width)) i_clock_gen_unit_sva (.*);
`default_nettype wire

//--- verif/osc_source_model.sv
// Oscillator and PLL sources facing the clock unit
`timescale 1ns/1ps
`default_nettype none
module osc_source_model
(
	input wire logic osc_enable,
	input wire logic pll_enable,
	input wire logic run,
	input wire logic lock_ok,
	output logic     osc_tick_int,
	output logic     osc_tick_ext,
	output logic     vco_tick,
	output logic     vco_base_tick,
	output logic     pll_locked
);
	// Periods unrelated to the system clock; a stopped source freezes, as real ones do
	initial {osc_tick_int, osc_tick_ext, vco_tick, vco_base_tick} = '0;
	always #170 if (osc_enable && run) osc_tick_int = ~osc_tick_int;
	always #190 if (osc_enable && run) osc_tick_ext = ~osc_tick_ext;
	always #130 if (pll_enable) vco_tick = ~vco_tick;
	always #230 if (pll_enable) vco_base_tick = ~vco_base_tick;
	assign pll_locked = pll_enable && lock_ok;
endmodule
`default_nettype wire

//--- verif/tb_clock_gen_unit.sv
// Self-checking bench for the clock generation unit
`timescale 1ns/1ps
`default_nettype none
module tb_clock_gen_unit;
	import cgu_pkg::*;
	logic clock, rst, watchdog_rst, wake_irq, run, lock_ok, pll_locked;
	logic osc_tick_int, osc_tick_ext, vco_tick, vco_base_tick, sys_tick, cpu_clock;
	logic periph_clock, fast_capture_clock, flash_fast_clock, clock_output_pin;
	logic osc_enable, pll_enable, ext_osc_select, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] feedback_divider_select, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, prev;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int bad_count, checks, sc, cc, pc, fc, oc, vc, bc, ic;
	clock_gen_unit i_clock_gen_unit (.*);
	osc_source_model i_osc_source_model (.*);
	initial
	begin
		clock = 0;
		forever #25 clock = ~clock;
	end
	task stop_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	function automatic logic near(int a, int b, int t);
		return a - b <= t && b - a <= t;
	endfunction
	// Sources are slower than the clock, so sampling on the falling edge sees every level
	always @(negedge clock)
	begin
		sc += sys_tick;
		cc += cpu_clock;
		pc += periph_clock;
		fc += fast_capture_clock;
		oc += clock_output_pin & ~prev[0];
		vc += vco_tick & ~prev[1];
		bc += vco_base_tick & ~prev[2];
		ic += osc_tick_int & ~prev[3];
		prev = {osc_tick_int, vco_base_tick, vco_tick, clock_output_pin};
	end
	task win(int n);
		{sc, cc, pc, fc, oc, vc, bc, ic} = '0;
		repeat (n) @(negedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= '0;
			if (s_axi_wready)
				s_axi_wvalid <= '0;
		end
		while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= '0;
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= '0;
		end
		while (!s_axi_rvalid);
		resp = s_axi_rresp;
		s_axi_rready <= '0;
		chk(n, s_axi_rdata & m, e);
	endtask
	task t_reset;
		rdc("ctrl", ctrl_offset, '1, 0);
		rdc("divider", divider_offset, 32'h0000_0fff, 32'h0000_0110);
		rdc("gates", gate_offset, 7, 7);
		rdc("power", power_offset, 3, 0);
	endtask
	task t_modes;
		int src;
		for (int i = 0; i < 4; i++)
		begin
			wr(ctrl_offset, i);
			repeat (40) @(posedge clock);
			rdc("mode", status_offset, 12, (i[0] ? 2 : int'(i[1])) << 2);
			win(600);
			src = i[0] ? bc : (i[1] ? ic : vc);
			chk("ticking", sc > 20, 1);
			chk("ratio", near(sc * 2, src, 3), 1);
			chk("pll run", pll_enable, i != 2);
		end
		wr(ctrl_offset, 0);
	endtask
	task t_idle;
		wr(power_offset, 1);
		win(200);
		chk("idle cpu", cc, 0);
		chk("idle periph", pc > 0, 1);
		@(posedge clock);
		wake_irq <= '1;
		@(posedge clock);
		wake_irq <= '0;
		win(200);
		chk("woken cpu", cc > 0, 1);
		chk("cpu third", near(cc * 3, sc, 5), 1);
		rdc("woken", power_offset, 3, 0);
	endtask
	task t_slow;
		wr(divider_offset, 32'h0000_0410);
		wr(power_offset, 2);
		win(1200);
		chk("slow cpu", near(cc * 12, sc, 24), 1);
		chk("slow capture", near(fc * 12, sc, 24), 1);
		wr(power_offset, 0);
		wr(divider_offset, 32'h0000_0110);
	endtask
	task t_pdown;
		wr(power_offset, 3);
		@(negedge clock);
		chk("osc off", osc_enable, 0);
		chk("pll off", pll_enable, 0);
		// Saving modes are entered from active only
		wr(power_offset, 1);
		rdc("still down", power_offset, 3, 3);
		wr(power_offset, 0);
		@(negedge clock);
		chk("osc on", osc_enable, 1);
	endtask
	task t_gate;
		wr(gate_offset, 0);
		win(300);
		chk("gated", pc + fc + oc, 0);
		chk("cpu runs", cc > 0, 1);
		wr(gate_offset, 7);
		wr(ctrl_offset, 8);
		win(600);
		chk("toggle out", near(oc * 2, sc, 2), 1);
		wr(ctrl_offset, 32'h0000_0010);
		win(600);
		chk("core out", near(oc * 3, sc, 4), 1);
		wr(ctrl_offset, 32'h0000_0028);
		win(600);
		chk("osc out", near(oc * 2, ic, 3), 1);
		wr(ctrl_offset, 32'h0000_0038);
		win(600);
		chk("slow out", near(oc * 6, sc, 7), 1);
		wr(ctrl_offset, 0);
	endtask
	task t_fail;
		wr(status_offset, 3);
		run <= '0;
		repeat (150) @(posedge clock);
		rdc("osc fail", status_offset, 1, 1);
		run <= '1;
		lock_ok <= '0;
		repeat (20) @(posedge clock);
		rdc("lock fail", status_offset, 2, 2);
		lock_ok <= '1;
		repeat (20) @(posedge clock);
		wr(status_offset, 3);
		rdc("cleared", status_offset, 3, 0);
	endtask
	task t_wdog;
		wr(divider_offset, 32'h0000_0120);
		@(negedge clock);
		chk("n", feedback_divider_select, 32);
		wr(divider_offset, 32'h0000_0114);
		wr(ctrl_offset, 4);
		@(negedge clock);
		chk("ext", ext_osc_select, 1);
		@(posedge clock);
		watchdog_rst <= '1;
		repeat (3) @(posedge clock);
		watchdog_rst <= '0;
		@(negedge clock);
		chk("wd n", feedback_divider_select, 20);
		chk("wd ext", ext_osc_select, 1);
		@(posedge clock);
		rst <= '1;
		repeat (5) @(posedge clock);
		rst <= '0;
		@(negedge clock);
		chk("por n", feedback_divider_select, 16);
		chk("por ext", ext_osc_select, 0);
		wr(8'h20, 1);
		chk("wr unmapped", resp, axi_slverr);
		rdc("rd unmapped", 8'h20, '1, 0);
		chk("rd resp", resp, axi_slverr);
	endtask
	initial
	begin
		{rst, s_axi_wstrb, run, lock_ok} = 7'h7f;
		{watchdog_rst, wake_irq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (5) @(posedge clock);
		rst <= '0;
		t_reset;
		t_modes;
		t_idle;
		t_slow;
		t_pdown;
		t_gate;
		t_fail;
		t_wdog;
		stop_test;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		stop_test;
	end
endmodule
`default_nettype wire
